// ---- design/fpss_seq.sv ----
`timescale 1ns/100ps
module fpss_seq #(
  parameter int STEP_CYC = fpss_pkg::STEP_CYC_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] func_sw_n,
  output logic [3:0] seq_addr_upper,
  output logic [3:0] seq_addr_lower,
  output logic seq_clear_n,
  output logic seq_ctr_clear,
  output logic addr_latch_strobe,
  output logic func_req
);
  // control states
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} fpss_state_t;

  fpss_step_if st ();

  logic [7:0] sw_s1_r; // first synchroniser stage
  logic [7:0] sw_s2_r; // second synchroniser stage
  logic pressed; // any switch low after sync
  logic [2:0] pick; // lowest pressed switch
  fpss_state_t state_r;
  fpss_state_t state_nxt;
  logic [2:0] fn_r; // latched function
  logic [2:0] fn_nxt;
  logic [3:0] upper_r; // upper address nibble
  logic [3:0] upper_nxt;
  logic clr_n_r; // low sequence clear
  logic clr_n_nxt;
  logic ctr_clr_r; // high counter clear
  logic ctr_clr_nxt;
  logic stb_r; // address latch strobe
  logic stb_nxt;
  logic req_r; // press-detect output
  logic req_nxt;

  // two-stage synchroniser on the switch pins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_s1_r <= 8'hFF;
      sw_s2_r <= 8'hFF;
    end
    else
    begin
      sw_s1_r <= func_sw_n;
      sw_s2_r <= sw_s1_r;
    end
  end

  // press detect and pick of the lowest pressed switch
  always_comb
  begin
    pressed = ~&sw_s2_r;
    pick = 3'h0;
    for (int i = fpss_pkg::NFUNC - 1; i >= 0; i--)
    begin
      if (!sw_s2_r[i])
        pick = 3'(i);
    end
  end

  // next state and outputs
  always_comb
  begin
    state_nxt = state_r;
    fn_nxt = fn_r;
    upper_nxt = upper_r;
    clr_n_nxt = 1'b1;
    stb_nxt = 1'b0;
    req_nxt = pressed;
    ctr_clr_nxt = ~clr_n_r;
    case (state_r)
      ST_IDLE:
      begin
        upper_nxt = fpss_pkg::UP_IDLE;
        if (pressed)
        begin
          // latch the function, pulse clear and strobe together
          fn_nxt = pick;
          upper_nxt = fpss_pkg::upper_of(pick);
          clr_n_nxt = 1'b0;
          stb_nxt = 1'b1;
          state_nxt = ST_ARM;
        end
      end
      ST_ARM:
      begin
        // counter clear is raised in the next cycle, the first in ST_RUN; then step
        state_nxt = pressed ? ST_RUN : ST_IDLE;
        if (!pressed)
          upper_nxt = fpss_pkg::UP_IDLE;
      end
      ST_RUN:
      begin
        // hold the block until release
        if (!pressed)
        begin
          upper_nxt = fpss_pkg::UP_IDLE;
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        upper_nxt = fpss_pkg::UP_IDLE;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // register state and outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      fn_r <= 3'h0;
      upper_r <= fpss_pkg::UP_IDLE;
      clr_n_r <= 1'b1;
      ctr_clr_r <= 1'b0;
      stb_r <= 1'b0;
      req_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      fn_r <= fn_nxt;
      upper_r <= upper_nxt;
      clr_n_r <= clr_n_nxt;
      ctr_clr_r <= ctr_clr_nxt;
      stb_r <= stb_nxt;
      req_r <= req_nxt;
    end
  end

  // counter link: steps only while held, lower pattern held after release
  assign st.clr = ctr_clr_r;
  assign st.run = (state_r == ST_RUN) && pressed;
  assign st.last = fpss_pkg::last_of(fn_r);

  fpss_step_ctr #(
    .STEP_CYC(STEP_CYC)
  ) u_ctr (
    .clk(clk),
    .nrst(nrst),
    .st(st)
  );

  assign seq_addr_upper = upper_r;
  assign seq_addr_lower = st.lower;
  assign seq_clear_n = clr_n_r;
  assign seq_ctr_clear = ctr_clr_r;
  assign addr_latch_strobe = stb_r;
  assign func_req = req_r;

  // upper nibble matches the held function
  a_upper_code: assert property (
    @(posedge clk) disable iff (!nrst)
    state_r == ST_RUN |-> upper_r == fpss_pkg::upper_of(fn_r))
    else $error("upper nibble does not match function");
  // idle means all high
  a_idle_high: assert property (
    @(posedge clk) disable iff (!nrst)
    state_r == ST_IDLE |-> upper_r == fpss_pkg::UP_IDLE)
    else $error("upper nibble not high when idle");
  // press raises request next cycle
  a_press_req: assert property (
    @(posedge clk) disable iff (!nrst)
    pressed |=> req_r)
    else $error("press not detected");
  // counter clear single cycle, shorter than the limit
  a_clr_width: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(ctr_clr_r) |=> !ctr_clr_r)
    else $error("counter clear too long");
  // counter clear follows the low sequence clear
  a_clr_follows: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(clr_n_r) |=> ctr_clr_r && clr_n_r)
    else $error("counter clear not derived from sequence clear");
  // strobe exactly with the sequence clear
  a_strobe_with: assert property (
    @(posedge clk) disable iff (!nrst)
    stb_r == !clr_n_r)
    else $error("strobe not concurrent with clear");
  // deposit never touches lower bits 2 and 3 once the count is cleared;
  // the clear cycle still shows the count of the previous block
  a_dep_bits: assert property (
    @(posedge clk) disable iff (!nrst)
    (state_r == ST_RUN && fn_r == fpss_pkg::FN_DEP && !st.clr) |->
      st.lower[3:2] == 2'h0)
    else $error("deposit moved lower bits 2 or 3");
  // upper stable while held, high one cycle after release
  a_upper_stable: assert property (
    @(posedge clk) disable iff (!nrst)
    (state_r == ST_RUN && pressed) |=> $stable(upper_r))
    else $error("upper nibble moved while held");
  a_release_high: assert property (
    @(posedge clk) disable iff (!nrst)
    (state_r == ST_RUN && !pressed) |=>
      upper_r == fpss_pkg::UP_IDLE ##1 upper_r == fpss_pkg::UP_IDLE)
    else $error("upper nibble not high after release");
  c_deposit: cover property (@(posedge clk) disable iff (!nrst)
    state_r == ST_RUN && fn_r == fpss_pkg::FN_DEP &&
      st.lower == fpss_pkg::LAST_DEP);
  c_output_fn: cover property (@(posedge clk) disable iff (!nrst)
    state_r == ST_RUN && fn_r == fpss_pkg::FN_OUTPUT);
  c_release: cover property (@(posedge clk) disable iff (!nrst)
    state_r == ST_RUN ##1 state_r == ST_IDLE);
endmodule : fpss_seq

// ---- design/fpss_pkg.sv ----
// shared constants for the front-panel switch sequencer
package fpss_pkg;
  // number of operator function switches
  localparam int NFUNC = 8;
  // switch index of each operator function
  localparam logic [2:0] FN_EXAM = 3'h0;
  localparam logic [2:0] FN_EXAM_NEXT = 3'h1;
  localparam logic [2:0] FN_DEP = 3'h2;
  localparam logic [2:0] FN_DEP_NEXT = 3'h3;
  localparam logic [2:0] FN_ACC_DISP = 3'h4;
  localparam logic [2:0] FN_ACC_LOAD = 3'h5;
  localparam logic [2:0] FN_INPUT = 3'h6;
  localparam logic [2:0] FN_OUTPUT = 3'h7;
  // upper sequence address nibble per function, and with nothing pressed
  localparam logic [3:0] UP_IDLE = 4'hF;
  localparam logic [3:0] UP_EXAM = 4'h7;
  localparam logic [3:0] UP_EXAM_NEXT = 4'hB;
  localparam logic [3:0] UP_DEP = 4'hD;
  localparam logic [3:0] UP_DEP_NEXT = 4'hE;
  localparam logic [3:0] UP_ACC_DISP = 4'h3;
  localparam logic [3:0] UP_ACC_LOAD = 4'h9;
  localparam logic [3:0] UP_INPUT = 4'hC;
  localparam logic [3:0] UP_OUTPUT = 4'hA;
  // last lower nibble visited in each function's block
  localparam logic [3:0] LAST_EXAM = 4'h7;
  localparam logic [3:0] LAST_EXAM_NEXT = 4'h3;
  localparam logic [3:0] LAST_DEP = 4'h3;
  localparam logic [3:0] LAST_DEP_NEXT = 4'h7;
  localparam logic [3:0] LAST_FULL = 4'hF;
  // reset value of the lower nibble
  localparam logic [3:0] LOW_RST = 4'h0;
  // clock period and timing figures
  localparam int CLK_NS = 8;
  localparam int CLR_MAX_NS = 100;
  // longest clear pulse, rounded down to whole cycles
  localparam int CLR_MAX_CYC = CLR_MAX_NS / CLK_NS;
  // whole sequence lasts about one second, in sixteen steps
  localparam longint SEQ_NS = 64'h0000_0000_3b9a_ca00;
  localparam int SEQ_STEPS = 16;
  localparam int STEP_CYC_DEF = int'(SEQ_NS / CLK_NS / SEQ_STEPS);

  // upper nibble of a function's block
  function automatic logic [3:0] upper_of(input logic [2:0] fn);
    case (fn)
      FN_EXAM: upper_of = UP_EXAM;
      FN_EXAM_NEXT: upper_of = UP_EXAM_NEXT;
      FN_DEP: upper_of = UP_DEP;
      FN_DEP_NEXT: upper_of = UP_DEP_NEXT;
      FN_ACC_DISP: upper_of = UP_ACC_DISP;
      FN_ACC_LOAD: upper_of = UP_ACC_LOAD;
      FN_INPUT: upper_of = UP_INPUT;
      default: upper_of = UP_OUTPUT;
    endcase
  endfunction : upper_of

  // final lower address of a function's block
  function automatic logic [3:0] last_of(input logic [2:0] fn);
    case (fn)
      FN_EXAM: last_of = LAST_EXAM;
      FN_EXAM_NEXT: last_of = LAST_EXAM_NEXT;
      FN_DEP: last_of = LAST_DEP;
      FN_DEP_NEXT: last_of = LAST_DEP_NEXT;
      default: last_of = LAST_FULL;
    endcase
  endfunction : last_of
endpackage : fpss_pkg

// ---- design/fpss_step_if.sv ----
`timescale 1ns/100ps
// link between the sequencer control and its step counter
interface fpss_step_if;
  logic clr; // high clear pulse to the step counter
  logic run; // stepping allowed
  logic [3:0] last; // final lower address of the block
  logic [3:0] lower; // lower sequence address from the counter
  modport ctrl (output clr, output run, output last, input lower);
  modport ctr (input clr, input run, input last, output lower);
endinterface : fpss_step_if

// ---- design/fpss_step_ctr.sv ----
`timescale 1ns/100ps
// step counter for the lower sequence address nibble
module fpss_step_ctr #(
  parameter int STEP_CYC = fpss_pkg::STEP_CYC_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  fpss_step_if.ctr st
);
  logic [31:0] pre_r; // prescaler for one step period
  logic [31:0] pre_nxt;
  logic [3:0] low_r; // lower address count
  logic [3:0] low_nxt;

  // next count: clear wins, then step until the block's last address
  always_comb
  begin
    pre_nxt = pre_r;
    low_nxt = low_r;
    if (st.clr)
    begin
      pre_nxt = 32'h0000_0000;
      low_nxt = fpss_pkg::LOW_RST;
    end
    else if (st.run && low_r != st.last)
    begin
      if (pre_r == 32'(STEP_CYC - 1))
      begin
        // step; stays within the block, deposit touches bits 0-1 only
        pre_nxt = 32'h0000_0000;
        low_nxt = low_r + 4'h1;
      end
      else
        pre_nxt = pre_r + 32'h0000_0001;
    end
  end

  // register the count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_r <= 32'h0000_0000;
      low_r <= fpss_pkg::LOW_RST;
    end
    else
    begin
      pre_r <= pre_nxt;
      low_r <= low_nxt;
    end
  end

  assign st.lower = low_r;

  // count never passes the final address while running; the clear
  // cycle still shows the count left over from the previous block
  a_lower_in_block: assert property (
    @(posedge clk) disable iff (!nrst)
    (st.run && !st.clr) |-> low_r <= st.last)
    else $error("lower address left the function block");
  // final address holds until cleared
  a_final_holds: assert property (
    @(posedge clk) disable iff (!nrst)
    (low_r == st.last && !st.clr) |=> low_r == $past(low_r))
    else $error("final address did not hold");
  c_reach_final: cover property (@(posedge clk) disable iff (!nrst)
    st.run && low_r == st.last);
endmodule : fpss_step_ctr

// ---- sim/fpss_panel_model.sv ----
`timescale 1ns/100ps
// operator switch bank: the bench names the held switches, and the
// contacts are driven onto the active-low pins at the falling edge
module fpss_panel_model (
  input wire logic clk,
  input wire logic [7:0] press_mask,
  output logic [7:0] func_sw_n
);
  // idle contacts rest high through their pull-ups
  initial func_sw_n = 8'hFF;
  // pins change only at the falling edge, away from the sampling edge
  always @(negedge clk)
  begin
    func_sw_n <= ~press_mask;
  end
endmodule : fpss_panel_model

// ---- sim/fpss_seq_tb.sv ----
`timescale 1ns/100ps
// self-checking bench for the front-panel switch sequencer
module fpss_seq_tb;
  localparam int STEP = 4; // short step time keeps the run brief
  logic clk; // 125 MHz clock
  logic nrst; // async reset, active low
  logic [7:0] press_mask; // switches held, active high
  logic [7:0] func_sw_n; // switch pins from the panel model
  logic [3:0] seq_addr_upper;
  logic [3:0] seq_addr_lower;
  logic seq_clear_n;
  logic seq_ctr_clear;
  logic addr_latch_strobe;
  logic func_req;
  int err_count;
  int num_checks;
  // expected upper codes and final lower addresses per switch
  logic [3:0] up_tab [8] = '{4'h7, 4'hB, 4'hD, 4'hE, 4'h3, 4'h9, 4'hC, 4'hA};
  logic [3:0] last_tab [8] = '{4'h7, 4'h3, 4'h3, 4'h7, 4'hF, 4'hF, 4'hF,
    4'hF};

  fpss_panel_model panel (.clk(clk), .press_mask(press_mask),
    .func_sw_n(func_sw_n));

  fpss_seq #(.STEP_CYC(STEP)) dut (.clk(clk), .nrst(nrst),
    .func_sw_n(func_sw_n), .seq_addr_upper(seq_addr_upper),
    .seq_addr_lower(seq_addr_lower), .seq_clear_n(seq_clear_n),
    .seq_ctr_clear(seq_ctr_clear), .addr_latch_strobe(addr_latch_strobe),
    .func_req(func_req));

  // compare one value and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // print counts and the verdict, then stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // wait, bounded, for the latch strobe of a taken press
  task automatic wait_strobe;
    int n;
    n = 0;
    @(negedge clk);
    while (addr_latch_strobe !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_strobe

  // nothing pressed after reset
  task automatic test_idle;
    check(seq_addr_upper, 4'hF);
    check(func_req, 1'b0);
    check(addr_latch_strobe, 1'b0);
    check(seq_clear_n, 1'b1);
    $display("test idle done");
  endtask : test_idle

  // full press, hold and release of one switch
  task automatic test_func(input int fn);
    int n;
    press_mask = 8'h01 << fn;
    wait_strobe();
    check(addr_latch_strobe, 1'b1);
    check(seq_clear_n, 1'b0);
    check(func_req, 1'b1);
    check(seq_addr_upper, up_tab[fn]);
    @(negedge clk);
    check(seq_ctr_clear, 1'b1);
    check({seq_clear_n, addr_latch_strobe}, 2'h2);
    @(negedge clk);
    check(seq_ctr_clear, 1'b0);
    check(seq_addr_lower, 4'h0);
    n = 0;
    while (seq_addr_lower !== last_tab[fn] && n < 20 * STEP)
    begin
      @(negedge clk);
      n++;
      check(seq_addr_upper, up_tab[fn]);
      check(seq_addr_lower <= last_tab[fn], 1'b1);
      if (fn == 2)
        check(seq_addr_lower[3:2], 2'h0);
    end
    repeat (3 * STEP) @(negedge clk);
    check(seq_addr_lower, last_tab[fn]);
    check(seq_addr_upper, up_tab[fn]);
    press_mask = 8'h00;
    repeat (5) @(negedge clk);
    check(seq_addr_upper, 4'hF);
    check(func_req, 1'b0);
    $display("test func %0d done", fn);
  endtask : test_func

  // a second switch pressed while one is held is ignored
  task automatic test_second_press;
    int n;
    press_mask = 8'h02;
    wait_strobe();
    @(negedge clk);
    press_mask = 8'h03;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += addr_latch_strobe;
    end
    check(n, 0);
    check(seq_addr_upper, 4'hB);
    press_mask = 8'h00;
    repeat (5) @(negedge clk);
    check(seq_addr_upper, 4'hF);
    $display("test second press done");
  endtask : test_second_press

  // reset in mid-sequence returns everything to idle
  task automatic test_reset_mid;
    press_mask = 8'h80;
    wait_strobe();
    repeat (2 * STEP) @(negedge clk);
    nrst = 1'b0;
    press_mask = 8'h00;
    @(negedge clk);
    check({seq_addr_upper, seq_addr_lower}, 8'hF0);
    check({seq_clear_n, seq_ctr_clear, addr_latch_strobe}, 3'h4);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check(seq_addr_upper, 4'hF);
    $display("test reset mid done");
  endtask : test_reset_mid

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    end_sim();
  end

  // main sequence
  initial
  begin
    err_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    press_mask = 8'h00;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    test_idle();
    for (int f = 0; f < 8; f++)
      test_func(f);
    test_second_press();
    test_reset_mid();
    end_sim();
  end
endmodule : fpss_seq_tb
